/* include/lle_pkg.sv */
// Shared constants, types and helpers for the logical error detect bank
// ****************************************************************
// ****************************************************************
package lle_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFF_HDR = 16'h1000;
  localparam logic [15:0] OFF_DET = 16'h1008;
  localparam logic [15:0] OFF_EN = 16'h100C;
  localparam logic [15:0] OFF_IRQ_STAT = 16'h1030;
  localparam logic [15:0] OFF_IRQ_CLR = 16'h1034;
  localparam logic [15:0] OFF_IRQ_EN = 16'h1038;

  // Bit numbers counted from the LSB; bit 0 of the map is the MSB
  localparam int BIT_ILL_REQ = 27;
  localparam int BIT_ILL_RESP = 23;
  localparam int BIT_UNSUP_PW = 22;

  localparam logic [15:0] NEXT_BLOCK_PTR = 16'h0000;
  localparam logic [15:0] FEATURE_BLOCK_ID = 16'h0007;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Error sources
  // ****************************************************************
  localparam int EV_N = 3;
  localparam int EV_REQ = 0;
  localparam int EV_RESP = 1;
  localparam int EV_PW = 2;
  localparam logic [EV_N-1:0] EV_RESET = 3'h0;

  // ****************************************************************
  // Packet header codes
  // ****************************************************************
  localparam logic [3:0] FTYPE_MAINT = 4'h8;
  localparam logic [3:0] TTYPE_RD_RESP = 4'h2;
  localparam logic [3:0] TTYPE_WR_RESP = 4'h3;
  localparam logic [3:0] TTYPE_PORT_WRITE = 4'h4;
  localparam logic [3:0] TTYPE_FIRST_ILLEGAL = 4'h5;
  localparam logic [7:0] HOP_TERMINATE = 8'h00;
  localparam int TT_UPPER_BIT = 1;

  typedef enum logic [2:0] {
    LLE_SEL_HDR,
    LLE_SEL_DET,
    LLE_SEL_EN,
    LLE_SEL_ISTAT,
    LLE_SEL_ICLR,
    LLE_SEL_IEN,
    LLE_SEL_NONE
  } lle_sel_t;

  function automatic logic [31:0] lle_spread(input logic [EV_N-1:0] v);
    logic [31:0] w;
    w = WORD_ZERO;
    w[BIT_ILL_REQ] = v[EV_REQ];
    w[BIT_ILL_RESP] = v[EV_RESP];
    w[BIT_UNSUP_PW] = v[EV_PW];
    return w;
  endfunction

  function automatic logic [EV_N-1:0] lle_gather(input logic [31:0] w);
    logic [EV_N-1:0] v;
    v = EV_RESET;
    v[EV_REQ] = w[BIT_ILL_REQ];
    v[EV_RESP] = w[BIT_ILL_RESP];
    v[EV_PW] = w[BIT_UNSUP_PW];
    return v;
  endfunction

endpackage

/* design/lle_pkt_check.sv */
// Classifies one incoming packet header into error events
`timescale 1ns/1ps
`default_nettype none
module lle_pkt_check
  import lle_pkg::*;
(
  input wire logic valid,
  input wire logic [3:0] ftype,
  input wire logic [3:0] ttype,
  input wire logic [1:0] tt,
  input wire logic [7:0] hop,
  output logic [EV_N-1:0] ev
);

  // ****************************************************************
  // Classification
  // ****************************************************************
  // Anything else never reaches this layer in a switch
  wire maint = valid && (ftype == FTYPE_MAINT) && (hop == HOP_TERMINATE);
  wire is_resp = (ttype == TTYPE_RD_RESP) || (ttype == TTYPE_WR_RESP);
  wire is_pw = (ttype == TTYPE_PORT_WRITE);
  wire is_req = !is_resp && !is_pw;
  wire bad_ttype = (ttype >= TTYPE_FIRST_ILLEGAL);
  wire bad_tt = tt[TT_UPPER_BIT];

  assign ev[EV_REQ] = maint && is_req && (bad_ttype || bad_tt);
  assign ev[EV_RESP] = maint && is_resp;
  assign ev[EV_PW] = maint && is_pw;

endmodule
`default_nettype wire

/* design/lle_apb_dec.sv */
// APB address decode and handshake for the detect bank
`timescale 1ns/1ps
`default_nettype none
module lle_apb_dec
  import lle_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  output lle_sel_t sel,
  output logic pready,
  output logic pslverr,
  output logic wr_fire,
  output logic rd_load
);

  logic rd_ok_q;
  logic rd_ok_d;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire [ADDR_W-3:0] word = paddr[ADDR_W-1:2];
  wire hit_hdr = (word == OFF_HDR[ADDR_W-1:2]);
  wire hit_det = (word == OFF_DET[ADDR_W-1:2]);
  wire hit_en = (word == OFF_EN[ADDR_W-1:2]);
  wire hit_istat = (word == OFF_IRQ_STAT[ADDR_W-1:2]);
  wire hit_iclr = (word == OFF_IRQ_CLR[ADDR_W-1:2]);
  wire hit_ien = (word == OFF_IRQ_EN[ADDR_W-1:2]);
  wire unmapped = !(hit_hdr || hit_det || hit_en || hit_istat ||
                    hit_iclr || hit_ien);

  assign sel = hit_hdr ? LLE_SEL_HDR :
               hit_det ? LLE_SEL_DET :
               hit_en ? LLE_SEL_EN :
               hit_istat ? LLE_SEL_ISTAT :
               hit_iclr ? LLE_SEL_ICLR :
               hit_ien ? LLE_SEL_IEN : LLE_SEL_NONE;

  // ****************************************************************
  // Handshake
  // ****************************************************************
  // Read data is registered, so the access waits until a live edge
  // has loaded it; a frozen clock enable stretches the access.
  assign pready = psel && penable && clk_en && rd_ok_q;
  assign pslverr = pready && unmapped;
  assign wr_fire = pready && pwrite;
  assign rd_load = psel && clk_en && !pready;
  assign rd_ok_d = rd_load;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ok_q <= 1'b0;
    end else if (clk_en) begin
      rd_ok_q <= rd_ok_d;
    end
  end

endmodule
`default_nettype wire

/* design/lle_regs.sv */
// Logical and transport layer error detect register bank with APB access
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module lle_regs
  import lle_pkg::*;
#(
  parameter int LANES = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic self_reset,
  input wire logic port_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LANES-1:0] pkt_valid,
  input wire logic [LANES-1:0][3:0] pkt_ftype,
  input wire logic [LANES-1:0][3:0] pkt_ttype,
  input wire logic [LANES-1:0][1:0] pkt_tt,
  input wire logic [LANES-1:0][7:0] pkt_hop,
  output logic irq,
  output logic report_req,
  output logic capture_lock,
  output logic log_strobe
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  lle_sel_t sel;
  logic wr_fire;
  logic rd_load;
  logic [LANES-1:0][EV_N-1:0] lane_ev;
  logic [EV_N-1:0] ev_any;
  logic [EV_N-1:0] det_q;
  logic [EV_N-1:0] det_d;
  logic [EV_N-1:0] en_q;
  logic [EV_N-1:0] en_d;
  logic [EV_N-1:0] istat_q;
  logic [EV_N-1:0] istat_d;
  logic [EV_N-1:0] ien_q;
  logic [EV_N-1:0] ien_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic strobe_q;
  logic strobe_d;
  logic irq_q;
  logic irq_d;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  lle_apb_dec u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .sel(sel),
    .pready(pready),
    .pslverr(pslverr),
    .wr_fire(wr_fire),
    .rd_load(rd_load)
  );

  wire soft_rst = self_reset || port_reset;
  wire wr_det = wr_fire && (sel == LLE_SEL_DET);
  wire wr_en = wr_fire && (sel == LLE_SEL_EN);
  wire wr_iclr = wr_fire && (sel == LLE_SEL_ICLR);
  wire wr_ien = wr_fire && (sel == LLE_SEL_IEN);
  wire [EV_N-1:0] wbits = lle_gather(pwdata);

  // ****************************************************************
  // Packet checkers, one per ingress lane
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      lle_pkt_check u_chk (
        .valid(pkt_valid[g]),
        .ftype(pkt_ftype[g]),
        .ttype(pkt_ttype[g]),
        .tt(pkt_tt[g]),
        .hop(pkt_hop[g]),
        .ev(lane_ev[g])
      );
    end
  endgenerate

  // Every source seen in this cycle is merged, none takes priority
  always_comb begin
    ev_any = EV_RESET;
    for (int i = 0; i < LANES; i++) begin
      ev_any = ev_any | lane_ev[i];
    end
  end

  // ****************************************************************
  // Detect flags and lock
  // ****************************************************************
  // Once an enabled flag stands, the log is frozen so the first error
  // and its capture stay consistent; later errors are not recorded.
  wire locked = |(det_q & en_q);
  wire [EV_N-1:0] ev_set = locked ? EV_RESET : ev_any;
  wire [EV_N-1:0] det_clr = wr_det ? ~wbits : EV_RESET;
  // A new error in the clearing cycle survives the clear only when no enabled flag stands
  assign det_d = (det_q & ~det_clr) | ev_set;
  wire [EV_N-1:0] newly_locked = ev_set & en_q;

  // ****************************************************************
  // Enables and interrupt status
  // ****************************************************************
  assign en_d = wr_en ? wbits : en_q;
  assign ien_d = wr_ien ? wbits : ien_q;
  wire [EV_N-1:0] istat_clr = wr_iclr ? wbits : EV_RESET;
  assign istat_d = (istat_q & ~istat_clr) | newly_locked;
  assign irq_d = |(istat_d & ien_d);
  assign strobe_d = |newly_locked;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Header and status words are constants or state only; writes to
  // them fall through with no effect, and the clear word reads zero.
  wire [31:0] hdr_word = {NEXT_BLOCK_PTR, FEATURE_BLOCK_ID};
  wire [31:0] rd_word = (sel == LLE_SEL_HDR) ? hdr_word :
                        (sel == LLE_SEL_DET) ? lle_spread(det_q) :
                        (sel == LLE_SEL_EN) ? lle_spread(en_q) :
                        (sel == LLE_SEL_ISTAT) ? lle_spread(istat_q) :
                        (sel == LLE_SEL_IEN) ? lle_spread(ien_q) :
                        WORD_ZERO;
  assign prdata_d = rd_load ? rd_word : prdata_q;

  // ****************************************************************
  // State
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_q <= EV_RESET;
      en_q <= EV_RESET;
    end else if (clk_en) begin
      if (soft_rst) begin
        det_q <= EV_RESET;
        en_q <= EV_RESET;
      end else begin
        det_q <= det_d;
        en_q <= en_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= EV_RESET;
      ien_q <= EV_RESET;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      if (soft_rst) begin
        istat_q <= EV_RESET;
        ien_q <= EV_RESET;
        irq_q <= 1'b0;
      end else begin
        istat_q <= istat_d;
        ien_q <= ien_d;
        irq_q <= irq_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= WORD_ZERO;
      strobe_q <= 1'b0;
    end else if (clk_en) begin
      prdata_q <= prdata_d;
      strobe_q <= soft_rst ? 1'b0 : strobe_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = prdata_q;
  assign irq = irq_q;
  assign capture_lock = locked;
  // Port-write request stays up while a reported error is logged
  assign report_req = locked;
  assign log_strobe = strobe_q;

endmodule
`default_nettype wire

/* verif/lle_regs_sva.sv */
// Concurrent checks on the logical error detect bank ports
`timescale 1ns/1ps
`default_nettype none
module lle_regs_sva
  import lle_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic self_reset,
  input wire logic port_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic report_req,
  input wire logic capture_lock,
  input wire logic log_strobe
);
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_done = psel && penable && pready && !pwrite;
  wire logic wr_done = psel && penable && pready && pwrite;
  wire logic clr = self_reset || port_reset;
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  AST_READY_QUAL: assert property (pready |-> psel && penable && clk_en)
    else $error("ready outside an access phase");
  AST_ZERO_WAIT: assert property (psel && !penable && clk_en
    ##1 penable && clk_en |-> pready) else $error("access not zero wait");
  AST_HDR_VALUE: assert property (
    rd_done && paddr == OFF_HDR |-> prdata == {NEXT_BLOCK_PTR,
    FEATURE_BLOCK_ID}) else $error("header word wrong");
  AST_DET_RSV: assert property (
    rd_done && paddr == OFF_DET |-> (prdata & 32'hF73F_FFFF) == 32'h0)
    else $error("detect reserved bit set");
  AST_EN_RSV: assert property (
    rd_done && paddr == OFF_EN |-> (prdata & 32'hF73F_FFFF) == 32'h0)
    else $error("enable reserved bit set");
  AST_LOCK_SAME: assert property (capture_lock == report_req)
    else $error("lock and report differ");
  AST_REPORT_RISE: assert property (
    $rose(report_req) |-> log_strobe || $past(wr_done))
    else $error("report rose with no logged error");
  AST_STROBE_REPORT: assert property (
    log_strobe && !$past(clr) |-> report_req)
    else $error("strobe without enabled error");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $past(wr_done) || $past(clr))
    else $error("irq fell with no write");
  AST_SELF_CLEAR: assert property (
    clr && clk_en |=> !report_req && !irq)
    else $error("soft reset left state");
  cover property (rd_done && pslverr);
  cover property ($rose(irq));
  cover property (log_strobe);
endmodule
bind lle_regs lle_regs_sva i_lle_regs_sva (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .self_reset(self_reset), .port_reset(port_reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .report_req(report_req), .capture_lock(capture_lock),
  .log_strobe(log_strobe));
`default_nettype wire

/* verif/tb_lle_regs.sv */
// Self-checking bench for the logical error detect bank
`timescale 1ns/1ps
`default_nettype none
module tb_lle_regs
  import lle_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic self_reset = 1'b0, port_reset = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, report_req, capture_lock, log_strobe, e;
  logic [1:0] pkt_valid = 2'h0;
  logic [1:0][3:0] pkt_ftype = 8'h0, pkt_ttype = 8'h0;
  logic [1:0][1:0] pkt_tt = 4'h0;
  logic [1:0][7:0] pkt_hop = 16'h0;
  int errors = 0, checks = 0;
  // Rows: ftype, ttype, tt, hop, then expected events pw/resp/req
  logic [23:0] rows [13] = '{24'h800000, 24'h850001, 24'h8F0001,
    24'h812001, 24'h813001, 24'h811000, 24'h820002, 24'h830002,
    24'h840004, 24'h840010, 24'h820FF0, 24'h850030, 24'h553000};
  always #4 pclk = ~pclk;
  lle_regs #(.LANES(2)) i_lle_regs (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .self_reset(self_reset), .port_reset(port_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_valid(pkt_valid), .pkt_ftype(pkt_ftype), .pkt_ttype(pkt_ttype),
    .pkt_tt(pkt_tt), .pkt_hop(pkt_hop), .irq(irq), .report_req(report_req),
    .capture_lock(capture_lock), .log_strobe(log_strobe));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready, read data and error are taken at the completing rising edge
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      errors++;
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic load(input int l, input logic [23:0] f);
    pkt_ftype[l] <= f[23:20];
    pkt_ttype[l] <= f[19:16];
    pkt_tt[l] <= f[13:12];
    pkt_hop[l] <= f[11:4];
  endtask
  task automatic fire(input logic [1:0] v);
    @(posedge pclk);
    pkt_valid <= v;
    @(posedge pclk);
    pkt_valid <= 2'h0;
  endtask
  // Strobe, irq, report and lock sampled mid-cycle after edge updates
  task automatic see(input logic [2:0] x);
    @(negedge pclk);
    chk({28'h0, log_strobe, irq, report_req, capture_lock},
      {28'h0, x, x[0]});
  endtask
  function automatic logic [31:0] ew(input logic [2:0] v);
    logic [31:0] w;
    w = 32'h0;
    w[BIT_ILL_REQ] = v[0];
    w[BIT_ILL_RESP] = v[1];
    w[BIT_UNSUP_PW] = v[2];
    return w;
  endfunction
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_HDR, 32'h0000_0007);
    rd(OFF_DET, 32'h0);
    rd(OFF_EN, 32'h0);
    wr(OFF_HDR, 32'hFFFF_FFFF);
    rd(OFF_HDR, 32'h0000_0007);
    wr(OFF_EN, 32'hFFFF_FFFF);
    rd(OFF_EN, 32'h08C0_0000);
    apb(1'b0, 16'h1004, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    wr(OFF_EN, 32'h0);
    foreach (rows[i]) begin
      load(0, rows[i]);
      fire(2'h1);
      rd(OFF_DET, ew(rows[i][2:0]));
      wr(OFF_DET, 32'h0);
    end
    load(0, 24'h820000);
    load(1, 24'h840000);
    fire(2'h3);
    rd(OFF_DET, 32'h00C0_0000);
    wr(OFF_DET, 32'h0040_0000);
    rd(OFF_DET, 32'h0040_0000);
    wr(OFF_DET, 32'h0);
    wr(OFF_EN, 32'h08C0_0000);
    wr(OFF_IRQ_EN, 32'h0040_0000);
    load(0, 24'h840000);
    fire(2'h1);
    see(3'h7);
    load(0, 24'h850000);
    fire(2'h1);
    rd(OFF_DET, 32'h0040_0000);
    wr(OFF_IRQ_EN, 32'h0);
    see(3'h1);
    wr(OFF_IRQ_EN, 32'h0040_0000);
    see(3'h3);
    rd(OFF_IRQ_STAT, 32'h0040_0000);
    wr(OFF_IRQ_CLR, 32'h0040_0000);
    see(3'h1);
    wr(OFF_DET, 32'h0);
    see(3'h0);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_EN, 32'hFFFF_FFFF);
      @(posedge pclk);
      self_reset <= (k == 0);
      port_reset <= (k == 1);
      @(posedge pclk);
      self_reset <= 1'b0;
      port_reset <= 1'b0;
      rd(OFF_EN, 32'h0);
    end
    final_report();
  end
endmodule
`default_nettype wire
